// file: core/cab_pkg.sv
// constants and types for the cell alert and balance control block
package cab_pkg;
   localparam int NCELL = 12;
   localparam int CW = 14;
   localparam int NAUX = 2;
   localparam logic [13:0] MISMATCH_THRESHOLD_DISABLE = 14'h3fff;
   localparam logic [15:0] MISMATCH_THRESHOLD_RESET = 16'hfffc;
   // clock rates
   localparam longint REF_HZ = 40000000;
   localparam longint LF_HZ_X1000 = 32768000;
   // 32.768 kHz tick from the 40 MHz reference (rounded down)
   localparam int LF_DIV = int'((REF_HZ * 1000) / LF_HZ_X1000);
   localparam logic [10:0] LF_DIV_M1 = 11'(LF_DIV - 1);
   // slow tick counts in 32.768 kHz periods
   localparam int LF_PER_S = 32768;
   localparam int HALF_S_TICKS = LF_PER_S / 2;
   localparam real OFF_MS = 62.5;
   localparam int OFF_TICKS = int'(OFF_MS * 32768.0 / 1000.0);
   localparam int CYCLE_S = 60;
   localparam int STEP_MS = 7500;
   localparam int CYCLE_TICKS = CYCLE_S * LF_PER_S;
   localparam int STEP_TICKS = STEP_MS * LF_PER_S / 1000;
   localparam int HOURS_PER_CODE = 2;
   localparam int HOUR_S = 3600;
   // emergency duration granularity: one count per 120 minute cycles (2 h)
   localparam int CYCLES_PER_CODE = HOURS_PER_CODE * HOUR_S / CYCLE_S;
   // balance prescaler: seconds per countdown step by code
   localparam logic [2:0] PDIV_OFF = 3'h0;
   localparam logic [3:0] ZERO4 = 4'h0;
   localparam logic [7:0] ZERO8 = 8'h00;

   typedef enum logic [1:0] {
      cab_ed_idle = 2'b00,
      cab_ed_on = 2'b01,
      cab_ed_off = 2'b11
   } cab_ed_state_t;

   function automatic logic [8:0] cab_pdiv_secs(input logic [2:0] code);
      case (code)
         3'h1: cab_pdiv_secs = 9'h001;
         3'h2: cab_pdiv_secs = 9'h004;
         3'h3: cab_pdiv_secs = 9'h010;
         3'h4: cab_pdiv_secs = 9'h040;
         3'h5: cab_pdiv_secs = 9'h080;
         3'h6: cab_pdiv_secs = 9'h100;
         default: cab_pdiv_secs = 9'h000;
      endcase
   endfunction
endpackage

// file: core/cab_lf_tick.sv
// divider giving one-cycle 32.768 kHz and 1 s enable pulses
`timescale 1ns/10ps
module cab_lf_tick
   import cab_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // enable pulses
   output logic lf_tick,
   output logic sec_tick,
   output logic half_sec_tick
);
   typedef struct packed {
      logic [10:0] div;
      logic [14:0] lf;
      logic lf_tick;
      logic sec_tick;
      logic half_sec_tick;
   } cab_tick_st_t;

   cab_tick_st_t st;
   cab_tick_st_t next_st;

   always_comb begin
      next_st = st;
      next_st.lf_tick = 1'b0;
      next_st.sec_tick = 1'b0;
      next_st.half_sec_tick = 1'b0;
      if (st.div == LF_DIV_M1) begin
         next_st.div = 11'h000;
         next_st.lf_tick = 1'b1;
         next_st.lf = st.lf + 15'h0001;
         if (st.lf[13:0] == 14'(HALF_S_TICKS - 1)) begin
            next_st.half_sec_tick = 1'b1;
         end
         if (st.lf == 15'(LF_PER_S - 1)) begin
            next_st.sec_tick = 1'b1;
         end
      end else begin
         next_st.div = st.div + 11'h001;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign lf_tick = st.lf_tick;
   assign sec_tick = st.sec_tick;
   assign half_sec_tick = st.half_sec_tick;
endmodule

// file: core/cab_core.sv
// measurement alert evaluation, statistics, balance watchdog, discharge
// Functional notes
// R01 - evaluate alerts at end of cycle, after last oversample only
// R02 - refresh alerts even without data move, enabled measurements only
// R03 - enabled cell above ov set threshold sets its ov flag
// R04 - enabled cell below uv set threshold sets its uv flag
// R05 - flags clear only on strict crossing of clear threshold
// R06 - summary ov/uv status is OR of per-cell flags
// R07 - per-cell combined alert is ov OR uv of that cell
// R08 - mismatch alert when max minus min exceeds 14-bit threshold
// R09 - record min/max cell index, highest index wins ties
// R10 - 16-bit sum of enabled cells; no cells enabled means no update
// R11 - aux cold/hot alerts on single thresholds, no hysteresis
// R12 - watchdog expiry forces switches off, enable register untouched
// R13 - 3-bit prescaler sets countdown step: off,1,4,16,64,128,256 s
// R14 - at zero switches stay off until disabled or nonzero written
// R15 - timer-output option drives pin three high while counting
// R16 - emergency mode needs enable bit and nonzero duration
// R17 - entry clears countdown, uses discharge select, drives pin three
// R18 - 4-bit activity counter counts at 2 Hz while active, wraps
// R19 - alternate odd/even minute cycles with 62.5 ms off at end
// R20 - duty code gives on-time in 7.5 s steps per minute
// R21 - clearing enable resets timer, returns switch and pin control
// R22 - ends on zero duration or timeout of 2 h per count plus 2 h
// R23 - compare thresholds on 14-bit left-justified result codes
// R24 - slow timers run off 32.768 kHz tick, control on main clock
`timescale 1ns/10ps
module cab_core
   import cab_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // measurement results from the arithmetic unit
   input wire logic meas_done,
   input wire logic last_oversample,
   input wire logic [NCELL*16-1:0] cell_result,
   input wire logic [NAUX*16-1:0] aux_result,
   // configuration
   input wire logic [NCELL-1:0] measurement_enable_cfg,
   input wire logic [NAUX-1:0] aux_measure_enable,
   input wire logic [NCELL-1:0] overvoltage_alert_enable,
   input wire logic [NCELL-1:0] undervoltage_alert_enable,
   input wire logic [NAUX-1:0] aux_alert_enable,
   input wire logic [15:0] ov_set_threshold,
   input wire logic [15:0] uv_set_threshold,
   input wire logic [15:0] ov_clear_threshold,
   input wire logic [15:0] uv_clear_threshold,
   input wire logic [15:0] mismatch_threshold,
   input wire logic [15:0] aux_overtemp_threshold,
   input wire logic [15:0] aux_undertemp_threshold,
   // balancing control
   input wire logic [NCELL-1:0] balance_switch_enable,
   input wire logic [2:0] balance_timer_prescale,
   input wire logic [3:0] countdown_wdata,
   input wire logic countdown_write,
   input wire logic pin3_timer_output_option,
   input wire logic pin3_gpio_level,
   // emergency discharge control
   input wire logic emergency_discharge_enable,
   input wire logic [7:0] discharge_duration,
   input wire logic [NCELL-1:0] discharge_switch_select,
   input wire logic [2:0] discharge_duty_window,
   // alert status
   output logic [NCELL-1:0] per_cell_ov_flags,
   output logic [NCELL-1:0] per_cell_uv_flags,
   output logic [NCELL-1:0] per_cell_combined_alert,
   output logic summary_ov_status,
   output logic summary_uv_status,
   output logic mismatch_alert,
   output logic [NAUX-1:0] cold_alert,
   output logic [NAUX-1:0] hot_alert,
   // statistics
   output logic [3:0] extreme_cell_index_min,
   output logic [3:0] extreme_cell_index_max,
   output logic [15:0] cell_total,
   // balancing outputs
   output logic [3:0] balance_countdown,
   output logic [NCELL-1:0] balance_switch_drive,
   output logic general_pin_three,
   output logic emergency_active,
   output logic [3:0] discharge_activity_counter
);
   typedef struct packed {
      logic [NCELL-1:0] ov;
      logic [NCELL-1:0] uv;
      logic msm;
      logic [NAUX-1:0] cold;
      logic [NAUX-1:0] hot;
      logic [3:0] imin;
      logic [3:0] imax;
      logic [15:0] total;
      logic [3:0] cbt;
      logic [8:0] cbsec;
      cab_ed_state_t ed;
      logic odd_phase;
      logic [21:0] cyc;
      logic [7:0] hour_cyc;
      logic [8:0] cyc_left;
      logic [3:0] act;
      logic [NCELL-1:0] sw;
      logic pin3;
      logic expired;
   } cab_st_t;

   cab_st_t st;
   cab_st_t next_st;
   logic lf_tick;
   logic sec_tick;
   logic half_sec_tick;

   cab_lf_tick u_tick (
      .ref_clk(ref_clk),
      .rst(rst),
      .lf_tick(lf_tick),
      .sec_tick(sec_tick),
      .half_sec_tick(half_sec_tick)
   );

   function automatic logic [13:0] cab_code(input logic [15:0] v);
      cab_code = v[15:2];
   endfunction

   function automatic logic [13:0] cell_code(input logic [NCELL*16-1:0] b,
                                             input int i);
      cell_code = cab_code(b[i*16 +: 16]);
   endfunction

   // statistics over enabled cells
   logic [13:0] vmin;
   logic [13:0] vmax;
   logic [3:0] amin;
   logic [3:0] amax;
   logic [15:0] vsum;
   logic any_cell;
   logic [13:0] c;

   always_comb begin
      vmin = 14'h3fff;
      vmax = 14'h0000;
      amin = 4'h0;
      amax = 4'h0;
      vsum = 16'h0000;
      any_cell = 1'b0;
      c = 14'h0000;
      for (int i = 0; i < NCELL; i++) begin
         c = cell_code(cell_result, i);
         if (measurement_enable_cfg[i]) begin
            // >= / <= so higher index wins ties [R09]
            if (!any_cell || c <= vmin) begin
               vmin = c;
               amin = 4'(i + 1);
            end
            if (!any_cell || c >= vmax) begin
               vmax = c;
               amax = 4'(i + 1);
            end
            vsum = vsum + {2'b00, c}; // [R10]
            any_cell = 1'b1;
         end
      end
   end

   logic [13:0] ovs;
   logic [13:0] ovc;
   logic [13:0] uvs;
   logic [13:0] uvc;
   logic [13:0] msm_thr;
   logic [14:0] spread;
   logic [7:0] ed_limit;
   logic [21:0] on_ticks;
   logic ed_req;
   logic cycle_end;
   // own code variable, the statistics process drives c
   logic [13:0] ce;

   always_comb begin
      ovs = cab_code(ov_set_threshold); // [R23]
      ovc = cab_code(ov_clear_threshold);
      uvs = cab_code(uv_set_threshold);
      uvc = cab_code(uv_clear_threshold);
      msm_thr = cab_code(mismatch_threshold);
      spread = {1'b0, vmax} - {1'b0, vmin};
      ed_limit = 8'(CYCLES_PER_CODE - 1);
      on_ticks = 22'(STEP_TICKS) * 22'({19'h0, discharge_duty_window} + 22'h1);
      if (discharge_duty_window == 3'h7) begin
         on_ticks = 22'(CYCLE_TICKS - OFF_TICKS); // [R20]
      end
      ed_req = emergency_discharge_enable && discharge_duration != ZERO8;
      cycle_end = lf_tick && st.cyc == 22'(CYCLE_TICKS - 1);
   end

   always_comb begin
      ce = 14'h0000;
      next_st = st;
      // alert evaluation, final oversample only [R01] [R02]
      if (meas_done && last_oversample) begin
         for (int i = 0; i < NCELL; i++) begin
            if (measurement_enable_cfg[i]) begin
               ce = cell_code(cell_result, i);
               if (overvoltage_alert_enable[i]) begin
                  if (ce > ovs) begin
                     next_st.ov[i] = 1'b1; // [R03]
                  end else if (ce < ovc) begin
                     next_st.ov[i] = 1'b0; // [R05]
                  end
               end
               if (undervoltage_alert_enable[i]) begin
                  if (ce < uvs) begin
                     next_st.uv[i] = 1'b1; // [R04]
                  end else if (ce > uvc) begin
                     next_st.uv[i] = 1'b0; // [R05]
                  end
               end
            end
         end
         if (any_cell) begin
            next_st.msm = spread > {1'b0, msm_thr}; // [R08]
            next_st.imin = amin; // [R09]
            next_st.imax = amax;
            next_st.total = vsum; // [R10]
         end
         for (int a = 0; a < NAUX; a++) begin
            if (aux_measure_enable[a] && aux_alert_enable[a]) begin
               next_st.cold[a] = cab_code(aux_result[a*16 +: 16]) >
                                 cab_code(aux_undertemp_threshold); // [R11]
               next_st.hot[a] = cab_code(aux_result[a*16 +: 16]) <
                                cab_code(aux_overtemp_threshold); // [R11]
            end
         end
      end
      // balance watchdog countdown, 32 kHz derived second [R24]
      if (countdown_write) begin
         next_st.cbt = countdown_wdata;
         next_st.cbsec = 9'h000;
      end else if (balance_timer_prescale != PDIV_OFF && sec_tick &&
                   st.cbt != ZERO4) begin
         if (st.cbsec + 9'h001 >= cab_pdiv_secs(balance_timer_prescale)) begin
            next_st.cbsec = 9'h000;
            next_st.cbt = st.cbt - 4'h1; // [R13]
         end else begin
            next_st.cbsec = st.cbsec + 9'h001;
         end
      end
      // emergency discharge sequencer
      case (st.ed)
         cab_ed_idle: begin
            // a timed-out run waits for enable or duration to drop
            if (!ed_req) begin
               next_st.expired = 1'b0;
            end else if (!st.expired) begin
               next_st.ed = cab_ed_on; // [R16]
               next_st.cbt = ZERO4; // [R17]
               next_st.cbsec = 9'h000;
               next_st.odd_phase = 1'b1;
               next_st.cyc = 22'h0;
               next_st.hour_cyc = 8'h00;
               next_st.cyc_left = {1'b0, discharge_duration} + 9'h001;
               next_st.act = ZERO4;
            end
         end
         cab_ed_on, cab_ed_off: begin
            if (lf_tick) begin
               next_st.cyc = st.cyc + 22'h1;
               if (st.cyc + 22'h1 >= on_ticks) begin
                  next_st.ed = cab_ed_off; // [R19]
               end
            end
            if (half_sec_tick) begin
               next_st.act = st.act + 4'h1; // [R18]
            end
            if (cycle_end) begin
               next_st.cyc = 22'h0;
               next_st.ed = cab_ed_on;
               next_st.odd_phase = !st.odd_phase; // [R19]
               if (st.hour_cyc == ed_limit) begin
                  next_st.hour_cyc = 8'h00;
                  next_st.cyc_left = st.cyc_left - 9'h001;
               end else begin
                  next_st.hour_cyc = st.hour_cyc + 8'h01;
               end
            end
            // release on enable clear, zero duration or timeout
            if (!ed_req || (cycle_end && st.hour_cyc == ed_limit &&
                            st.cyc_left == 9'h001)) begin
               next_st.ed = cab_ed_idle; // [R21] [R22]
               next_st.cyc = 22'h0;
               next_st.hour_cyc = 8'h00;
               next_st.cyc_left = 9'h000;
               // timeout with the request still up blocks re-entry
               next_st.expired = ed_req; // [R22]
            end
         end
         default: next_st.ed = cab_ed_idle;
      endcase
      // switch and pin drive
      if (st.ed == cab_ed_on) begin
         for (int i = 0; i < NCELL; i++) begin
            // cell i+1 odd when i even
            next_st.sw[i] = discharge_switch_select[i] &&
                            (st.odd_phase == !i[0]); // [R17] [R19]
         end
         next_st.pin3 = 1'b1; // [R17]
      end else if (st.ed == cab_ed_off) begin
         next_st.sw = '0;
         next_st.pin3 = 1'b1;
      end else begin
         // expired timer holds switches off, prescaler off passes enables [R12] [R14]
         if (balance_timer_prescale == PDIV_OFF || st.cbt != ZERO4) begin
            next_st.sw = balance_switch_enable;
         end else begin
            next_st.sw = '0;
         end
         if (pin3_timer_output_option) begin
            next_st.pin3 = balance_timer_prescale != PDIV_OFF &&
                           st.cbt != ZERO4; // [R15]
         end else begin
            next_st.pin3 = pin3_gpio_level; // [R21]
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign per_cell_ov_flags = st.ov;
   assign per_cell_uv_flags = st.uv;
   assign per_cell_combined_alert = st.ov | st.uv; // [R07]
   assign summary_ov_status = |st.ov; // [R06]
   assign summary_uv_status = |st.uv; // [R06]
   assign mismatch_alert = st.msm;
   assign cold_alert = st.cold;
   assign hot_alert = st.hot;
   assign extreme_cell_index_min = st.imin;
   assign extreme_cell_index_max = st.imax;
   assign cell_total = st.total;
   assign balance_countdown = st.cbt;
   assign balance_switch_drive = st.sw;
   assign general_pin_three = st.pin3;
   assign emergency_active = st.ed != cab_ed_idle;
   assign discharge_activity_counter = st.act;
endmodule

// file: testbench/cab_core_assertions.sv
// concurrent checks on the ports of the alert and balance core
`timescale 1ns/10ps
module cab_core_assertions
   import cab_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // stimulus side
   input wire logic meas_done,
   input wire logic last_oversample,
   input wire logic [NCELL*16-1:0] cell_result,
   input wire logic [NCELL-1:0] measurement_enable_cfg,
   input wire logic [NCELL-1:0] overvoltage_alert_enable,
   input wire logic [15:0] ov_set_threshold,
   input wire logic [2:0] balance_timer_prescale,
   input wire logic [3:0] countdown_wdata,
   input wire logic countdown_write,
   input wire logic pin3_timer_output_option,
   input wire logic emergency_discharge_enable,
   input wire logic [7:0] discharge_duration,
   // results
   input wire logic [NCELL-1:0] per_cell_ov_flags,
   input wire logic [NCELL-1:0] per_cell_uv_flags,
   input wire logic [NCELL-1:0] per_cell_combined_alert,
   input wire logic summary_ov_status,
   input wire logic [3:0] balance_countdown,
   input wire logic [NCELL-1:0] balance_switch_drive,
   input wire logic general_pin_three,
   input wire logic emergency_active
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic ev;
   assign ev = meas_done && last_oversample;
   logic req;
   assign req = emergency_discharge_enable && discharge_duration != 8'h00;
   sequence s_fresh_req;
      !req ##1 (req && !emergency_active);
   endsequence
   sequence s_enter;
      !emergency_active ##1 emergency_active;
   endsequence
   summary_ov_a:
   assert property (summary_ov_status == |per_cell_ov_flags)
      else $error("bad ov summary");
   combined_alert_a:
   assert property (per_cell_combined_alert ==
      (per_cell_ov_flags | per_cell_uv_flags)) else $error("bad combined");
   flags_hold_a:
   assert property (!ev |=> $stable(per_cell_ov_flags) &&
      $stable(per_cell_uv_flags)) else $error("flags moved without eval");
   ov_set_a:
   assert property (ev && measurement_enable_cfg[0] &&
      overvoltage_alert_enable[0] &&
      cell_result[15:2] > ov_set_threshold[15:2] |=> per_cell_ov_flags[0])
      else $error("ov flag not set");
   ov_equal_a:
   assert property (ev && cell_result[15:2] == ov_set_threshold[15:2] &&
      !per_cell_ov_flags[0] |=> !per_cell_ov_flags[0])
      else $error("ov set on equality");
   emer_entry_a:
   assert property (s_fresh_req |=> emergency_active &&
      balance_countdown == 4'h0) else $error("no discharge entry");
   zero_duration_a:
   assert property (discharge_duration == 8'h00 |=> !emergency_active)
      else $error("active with zero duration");
   emer_exit_a:
   assert property (!emergency_discharge_enable |=> !emergency_active)
      else $error("active after enable cleared");
   odd_first_a:
   assert property (s_enter |=> (balance_switch_drive & 12'haaa) == 12'h000)
      else $error("even cells on in first cycle");
   emer_pin_a:
   assert property (emergency_active [*2] |-> general_pin_three)
      else $error("pin three low in discharge");
   load_count_a:
   assert property (countdown_write && balance_timer_prescale != 3'h0 &&
      !emergency_discharge_enable && !emergency_active |=>
      balance_countdown == $past(countdown_wdata)) else $error("no load");
   zero_off_a:
   assert property ((balance_countdown == 4'h0 && !emergency_active &&
      balance_timer_prescale != 3'h0) [*2] |-> balance_switch_drive == 12'h000)
      else $error("switches on after expiry");
   timer_pin_a:
   assert property ((pin3_timer_output_option && !emergency_active &&
      balance_countdown != 4'h0 && balance_timer_prescale != 3'h0) [*2]
      |-> general_pin_three) else $error("pin three low while counting");
endmodule

bind cab_core cab_core_assertions cab_core_assertions_i(.ref_clk, .rst,
   .meas_done, .last_oversample, .cell_result, .measurement_enable_cfg,
   .overvoltage_alert_enable, .ov_set_threshold, .balance_timer_prescale,
   .countdown_wdata, .countdown_write, .pin3_timer_output_option,
   .emergency_discharge_enable, .discharge_duration, .per_cell_ov_flags,
   .per_cell_uv_flags, .per_cell_combined_alert, .summary_ov_status,
   .balance_countdown, .balance_switch_drive, .general_pin_three,
   .emergency_active);

// file: testbench/cab_core_bench.sv
// self-checking bench for the alert and balance core
`timescale 1ns/10ps
module cab_core_bench;
   import cab_pkg::*;
   logic ref_clk = 0, rst = 1, meas_done = 0, last_oversample = 0;
   logic [NCELL*16-1:0] cell_result = '0;
   logic [NAUX*16-1:0] aux_result = {16'h0190, 16'h2ee0};
   logic [NCELL-1:0] measurement_enable_cfg = '1;
   logic [NCELL-1:0] overvoltage_alert_enable = '1;
   logic [NCELL-1:0] undervoltage_alert_enable = '1;
   logic [NCELL-1:0] balance_switch_enable = 12'hfff;
   logic [NCELL-1:0] discharge_switch_select = 12'hfff;
   logic [NAUX-1:0] aux_measure_enable = '1, aux_alert_enable = '1;
   logic [15:0] ov_set_threshold = 16'h2ee0, ov_clear_threshold = 16'h2d50;
   logic [15:0] uv_set_threshold = 16'h0fa0, uv_clear_threshold = 16'h1130;
   logic [15:0] mismatch_threshold = 16'h07d0;
   logic [15:0] aux_overtemp_threshold = 16'h0320;
   logic [15:0] aux_undertemp_threshold = 16'h2710;
   logic [2:0] balance_timer_prescale = 3'h0, discharge_duty_window = 3'h0;
   logic [3:0] countdown_wdata = 4'h0;
   logic countdown_write = 0, pin3_timer_output_option = 0;
   logic pin3_gpio_level = 0, emergency_discharge_enable = 0;
   logic [7:0] discharge_duration = 8'h00;
   logic [NCELL-1:0] per_cell_ov_flags, per_cell_uv_flags;
   logic [NCELL-1:0] per_cell_combined_alert, balance_switch_drive;
   logic summary_ov_status, summary_uv_status, mismatch_alert;
   logic [NAUX-1:0] cold_alert, hot_alert;
   logic [3:0] extreme_cell_index_min, extreme_cell_index_max;
   logic [3:0] balance_countdown, discharge_activity_counter;
   logic [15:0] cell_total;
   logic general_pin_three, emergency_active;
   logic [13:0] code [NCELL];
   int failures = 0, check_count = 0;

   cab_core cab_core_i(.ref_clk, .rst, .meas_done, .last_oversample,
      .cell_result, .aux_result, .measurement_enable_cfg,
      .aux_measure_enable, .overvoltage_alert_enable,
      .undervoltage_alert_enable, .aux_alert_enable, .ov_set_threshold,
      .uv_set_threshold, .ov_clear_threshold, .uv_clear_threshold,
      .mismatch_threshold, .aux_overtemp_threshold, .aux_undertemp_threshold,
      .balance_switch_enable, .balance_timer_prescale, .countdown_wdata,
      .countdown_write, .pin3_timer_output_option, .pin3_gpio_level,
      .emergency_discharge_enable, .discharge_duration,
      .discharge_switch_select, .discharge_duty_window, .per_cell_ov_flags,
      .per_cell_uv_flags, .per_cell_combined_alert, .summary_ov_status,
      .summary_uv_status, .mismatch_alert, .cold_alert, .hot_alert,
      .extreme_cell_index_min, .extreme_cell_index_max, .cell_total,
      .balance_countdown, .balance_switch_drive, .general_pin_three,
      .emergency_active, .discharge_activity_counter);

   initial forever #12.5 ref_clk = ~ref_clk;

   task stop_test;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task check(input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("mismatch at %0t: saw %h want %h", $time, s, e);
      end
   endtask

   task step(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // one result hand-over; lo marks the final oversample
   task meas(input logic lo);
      for (int i = 0; i < NCELL; i++)
         cell_result[i*16+:16] = {code[i], 2'h0};
      meas_done = 1;
      last_oversample = lo;
      step(1);
      meas_done = 0;
   endtask

   task flags(input logic [11:0] ov, input logic [11:0] uv);
      check(per_cell_ov_flags, ov);
      check(per_cell_uv_flags, uv);
      check(per_cell_combined_alert, ov | uv);
      check(summary_ov_status, |ov);
      check(summary_uv_status, |uv);
   endtask

   // expected statistics with every cell enabled
   task stats;
      logic [3:0] mn, mx;
      logic [15:0] t;
      mn = 4'h1;
      mx = 4'h1;
      t = 16'h0000;
      for (int i = 0; i < NCELL; i++) begin
         t += code[i];
         if (code[i] <= code[mn-1]) mn = 4'(i + 1);
         if (code[i] >= code[mx-1]) mx = 4'(i + 1);
      end
      check(extreme_cell_index_min, mn);
      check(extreme_cell_index_max, mx);
      check(cell_total, t);
      check(mismatch_alert,
         (code[mx-1] - code[mn-1]) > mismatch_threshold[15:2]);
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      stop_test;
   end

   initial begin
      for (int i = 0; i < NCELL; i++)
         code[i] = 14'h7d0;
      step(5);
      check(balance_switch_drive, 12'h000);
      rst = 0;
      step(1);
      check(balance_switch_drive, 12'hfff);
      code[0] = 14'hbb9;
      code[1] = 14'h3e7;
      code[2] = 14'hbb8;
      code[4] = 14'h3e7;
      code[8] = 14'h3e7;
      meas(1);
      flags(12'h001, 12'h112);
      stats;
      check(cold_alert, 2'b01);
      check(hot_alert, 2'b10);
      code[0] = 14'hb86;
      code[1] = 14'h44c;
      meas(1);
      flags(12'h001, 12'h112);
      code[0] = 14'h7d0;
      code[4] = 14'h7d0;
      meas(0);
      flags(12'h001, 12'h112);
      code[0] = 14'hb53;
      code[1] = 14'h44d;
      meas(1);
      flags(12'h000, 12'h100);
      stats;
      overvoltage_alert_enable = 12'hffe;
      code[0] = 14'hbb9;
      meas(1);
      flags(12'h000, 12'h100);
      overvoltage_alert_enable = '1;
      for (int i = 0; i < NCELL; i++)
         code[i] = 14'h7d0;
      meas(1);
      flags(12'h000, 12'h000);
      stats;
      measurement_enable_cfg = '0;
      code[3] = 14'h000;
      meas(1);
      code[3] = 14'h7d0;
      flags(12'h000, 12'h000);
      stats;
      measurement_enable_cfg = '1;
      // balancing watchdog and pin three
      pin3_gpio_level = 1;
      step(2);
      check(balance_switch_drive, 12'hfff);
      check(general_pin_three, 1'b1);
      balance_timer_prescale = 3'h1;
      pin3_gpio_level = 0;
      pin3_timer_output_option = 1;
      step(2);
      check(balance_switch_drive, 12'h000);
      countdown_wdata = 4'h5;
      countdown_write = 1;
      step(1);
      countdown_write = 0;
      step(2);
      check(balance_countdown, 4'h5);
      check(balance_switch_drive, 12'hfff);
      check(general_pin_three, 1'b1);
      // emergency discharge
      emergency_discharge_enable = 1;
      step(3);
      check(emergency_active, 1'b0);
      discharge_duration = 8'h01;
      step(3);
      check(emergency_active, 1'b1);
      check(balance_countdown, 4'h0);
      check(balance_switch_drive, 12'h555);
      check(general_pin_three, 1'b1);
      check(discharge_activity_counter, 4'h0);
      balance_timer_prescale = 3'h0;
      pin3_timer_output_option = 0;
      balance_switch_enable = 12'h0f0;
      emergency_discharge_enable = 0;
      step(3);
      check(emergency_active, 1'b0);
      check(balance_switch_drive, 12'h0f0);
      check(general_pin_three, 1'b0);
      emergency_discharge_enable = 1;
      step(3);
      check(emergency_active, 1'b1);
      discharge_duration = 8'h00;
      step(3);
      check(emergency_active, 1'b0);
      check(balance_switch_drive, 12'h0f0);
      stop_test;
   end
endmodule
